//--- pkg/oog_pkg.sv
package oog_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FAS_LO = 8'h04;
  localparam logic [7:0] ADDR_FAS_HI = 8'h08;
  localparam logic [7:0] ADDR_GCC = 8'h0c;
  localparam logic [7:0] ADDR_MUX = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TTI_WR = 8'h18;
  localparam logic [7:0] ADDR_FTFL_WR = 8'h1c;
  localparam logic [7:0] ADDR_MON0 = 8'h20;
  localparam logic [7:0] ADDR_MON7 = 8'h3c;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_COMMIT_BIT = 1;
  localparam int MON_BIAE_BIT = 4;
  localparam int MON_BDI_BIT = 5;
  localparam int MON_IAE_BIT = 6;
  localparam int MON_STAT_LSB = 8;
  localparam int MUX_M2_LSB = 8;
  localparam int MUX_M3_BIT = 16;
  localparam int MUX_OTU_LSB = 20;
  localparam int ST_BANK_BIT = 8;
  localparam int ST_PEND_BIT = 9;
  localparam int ST_TS_LSB = 12;
  // Reset values
  localparam logic [47:0] FAS_RST = 48'hf6f6f6282828;
  // Frame byte positions
  localparam logic [5:0] POS_FAS = 6'h00;
  localparam logic [5:0] POS_MFAS = 6'h06;
  localparam logic [5:0] POS_SM = 6'h07;
  localparam logic [5:0] POS_GCC = 6'h0a;
  localparam logic [5:0] POS_TCM = 6'h0d;
  localparam logic [5:0] POS_FTFL = 6'h1f;
  localparam logic [5:0] POS_PM = 6'h20;
  localparam logic [5:0] POS_MUX = 6'h23;
  localparam logic [5:0] POS_LAST = 6'h3f;
  localparam logic [2:0] MON_PM = 3'h7;
  // Codes
  localparam logic [3:0] BEI_BIAE = 4'hb;
  localparam logic [3:0] BEI_MAX = 4'h8;
  localparam logic [2:0] STAT_NOSRC = 3'h0;
  localparam logic [2:0] STAT_NORMAL = 3'h1;
  localparam logic [2:0] STAT_RES_A = 3'h3;
  localparam logic [2:0] STAT_RES_B = 3'h4;
  localparam logic [2:0] STAT_LCK = 3'h5;
  localparam logic [2:0] STAT_OCI = 3'h6;
  localparam logic [2:0] STAT_AIS = 3'h7;
  localparam logic [7:0] FIF_NONE = 8'h00;
  localparam logic [7:0] FIF_SD = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    M1_NONE, M1_41, M1_42, M1_48_ODU2, M1_48_EXT, M1_48_ODU2E, M1_31,
    M1_23_PT20, M1_23_PT20_EXT, M1_23_PT21, M1_23_PT21_EXT, M1_13_PT20,
    M1_13_PT21, M1_2E3E1, M1_3E28, M1_21, M1_ODU2_EXT, M1_12_PT20,
    M1_12_PT21, M1_01
  } oog_mux1_t;
  typedef enum logic [2:0] {M2_NONE, M2_21, M2_12_PT20, M2_12_PT21, M2_01} oog_mux2_t;
  typedef enum logic [3:0] {
    OTU_1, OTU_2, OTU_2X, OTU_1E, OTU_2E, OTU_1F, OTU_2F, OTU_3, OTU_3E1, OTU_3E2, OTU_4
  } oog_otu_t;
endpackage : oog_pkg

//--- logic/oog_top.sv
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// - Alignment word defaults F6 F6 F6 28 28 28; each byte programmable.
// - Multiframe byte counts frames 0 to 255, then wraps to 0.
// - Each trace is 64 bytes, one per frame, indexed by multiframe count.
// - Trace holds source id, destination id and 32-byte operator part.
// - Section third byte: error code bits 1-4, defect bit 5, alignment bit 6.
// - Error counts 0-8 coded 0000-1000; 1001-1111 mean zero.
// - Code 1011 alone flags backward alignment error in section and tandem bytes.
// - Defect bit is 1 when signal fail is reported, else 0.
// - Section alignment bit is 1 to report frame alignment error.
// - Tandem third byte: error bits 1-4, defect bit 5, status bits 6-8.
// - Tandem status codes 000,001,010,101,110,111; 011 and 100 reserved.
// - Section, tandem and path each carry trace, parity and third byte.
// - Fault message has forward and backward 128-byte fields, both programmable.
// - Fault byte 00 none, 01 fail, 02 degrade; higher values reserved.
// - Operator id: three-char country code, one to six char segment code.
// - Path error field reports errored parity blocks seen by far sink.
// - Path third byte: count only in bits 1-4, defect bit 5, status 6-8.
// - Communication channel bytes are programmable hexadecimal values.
// - First stage picks container; slot types use one, two or eight slots.
// - PT=20 variants use 2.5G slots, PT=21 variants 1.25G slots.
// - Second stage only with a valid first stage: none, 2.1, 12 both, 01.
// - Third stage only for OTU4 or OTU3: none or 01.
// - Path status 001 normal, 101 locked, 110 open, 111 AIS; rest reserved.
module oog_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] pay_data,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_sof,
  output logic tx_pay,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    logic [5:0] pos;
    logic [7:0] mfas;
    logic bank;
    logic pend;
    logic en;
    logic [47:0] fas_sh;
    logic [47:0] fas;
    logic [7:0][10:0] mon_sh;
    logic [7:0][10:0] mon;
    logic [23:0] gcc_sh;
    logic [23:0] gcc;
    logic [23:0] mux_sh;
    logic [23:0] mux;
    logic [7:0] bip_acc;
    logic [7:0] bip_prev;
    logic [7:0] bip_out;
    logic [7:0] tx_data;
    logic tx_sof;
    logic tx_valid;
    logic tx_pay;
    logic [7:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } oog_state_t;

  oog_state_t s;
  oog_state_t n;
  // Two banks: software fills the idle one, or the live one while stopped; swap at wrap
  logic [7:0] tti_mem [0:1][0:511];
  logic [7:0] ftfl_mem [0:1][0:255];
  logic wr_fire;
  logic tti_we;
  logic ftfl_we;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [3:0] enc_bei(input logic [3:0] cnt, input logic biae);
    if (biae) begin
      return oog_pkg::BEI_BIAE;
    end else if (cnt > oog_pkg::BEI_MAX) begin
      return 4'h0;
    end
    return cnt;
  endfunction : enc_bei

  function automatic logic [2:0] fix_stat(input logic [2:0] st, input logic pm);
    if (pm) begin
      if (st == oog_pkg::STAT_LCK || st == oog_pkg::STAT_OCI || st == oog_pkg::STAT_AIS) begin
        return st;
      end
      return oog_pkg::STAT_NORMAL;
    end
    if (st == oog_pkg::STAT_RES_A || st == oog_pkg::STAT_RES_B) begin
      return oog_pkg::STAT_NOSRC;
    end
    return st;
  endfunction : fix_stat

  assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
  assign tti_we = wr_fire && s.awaddr[7:2] == oog_pkg::ADDR_TTI_WR[7:2] && s.wstrb[0];
  assign ftfl_we = wr_fire && s.awaddr[7:2] == oog_pkg::ADDR_FTFL_WR[7:2] && s.wstrb[0];

  // Trace index = monitor*64 + byte: source id, destination id, operator part
  always_ff @(posedge clk_sys) begin
    if (tti_we) begin
      tti_mem[s.bank ^ s.en][s.wdata[16:8]] <= s.wdata[7:0];
    end
    if (ftfl_we) begin
      ftfl_mem[s.bank ^ s.en][s.wdata[15:8]] <= s.wdata[7:0];
    end
  end

  always_comb begin
    logic [2:0] mi;
    logic [1:0] sub;
    logic mon_hit;
    logic [10:0] cfg;
    logic [3:0] bei;
    logic [7:0] ob;
    logic [7:0] fb;
    logic [4:0] m1;
    logic [2:0] m2;
    logic m1v;
    logic m3;
    logic ts25;
    logic [1:0] slots;
    logic [3:0] otu;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] w;
    n = s;
    mi = 3'h0;
    sub = 2'h0;
    mon_hit = 1'b0;
    ob = 8'h00;
    fb = 8'h00;
    ts25 = 1'b0;
    slots = 2'h0;
    wa = {s.awaddr[7:2], 2'b00};
    ra = {araddr[7:2], 2'b00};
    w = 32'h0;
    // Multiplexing structure
    m1 = s.mux[4:0];
    case (m1)
      oog_pkg::M1_41, oog_pkg::M1_31, oog_pkg::M1_21, oog_pkg::M1_ODU2_EXT: slots = 2'h1;
      oog_pkg::M1_42: slots = 2'h2;
      oog_pkg::M1_48_ODU2, oog_pkg::M1_48_EXT, oog_pkg::M1_48_ODU2E: slots = 2'h3;
      oog_pkg::M1_23_PT20, oog_pkg::M1_23_PT20_EXT, oog_pkg::M1_13_PT20,
      oog_pkg::M1_3E28, oog_pkg::M1_12_PT20: ts25 = 1'b1;
      default: ts25 = 1'b0;
    endcase
    m1v = m1 != oog_pkg::M1_NONE && m1 <= oog_pkg::M1_01;
    m2 = s.mux[oog_pkg::MUX_M2_LSB +: 3];
    if (!m1v || m2 > oog_pkg::M2_01) begin
      m2 = oog_pkg::M2_NONE;
    end
    otu = s.mux[oog_pkg::MUX_OTU_LSB +: 4];
    m3 = s.mux[oog_pkg::MUX_M3_BIT] && m2 != oog_pkg::M2_NONE &&
         (otu == oog_pkg::OTU_3 || otu == oog_pkg::OTU_4);
    // Monitoring byte groups
    if (s.pos >= oog_pkg::POS_SM && s.pos < oog_pkg::POS_GCC) begin
      mon_hit = 1'b1;
      sub = 2'(s.pos - oog_pkg::POS_SM);
    end else if (s.pos >= oog_pkg::POS_TCM && s.pos < oog_pkg::POS_FTFL) begin
      mon_hit = 1'b1;
      mi = 3'((s.pos - oog_pkg::POS_TCM) / 3 + 1);
      sub = 2'((s.pos - oog_pkg::POS_TCM) % 3);
    end else if (s.pos >= oog_pkg::POS_PM && s.pos < oog_pkg::POS_MUX) begin
      mon_hit = 1'b1;
      mi = oog_pkg::MON_PM;
      sub = 2'(s.pos - oog_pkg::POS_PM);
    end
    cfg = s.mon[mi];
    bei = enc_bei(cfg[3:0], cfg[oog_pkg::MON_BIAE_BIT] && mi != oog_pkg::MON_PM);
    if (mon_hit) begin
      if (sub == 2'h0) begin
        ob = tti_mem[s.bank][{mi, s.mfas[5:0]}];
      end else if (sub == 2'h1) begin
        ob = s.bip_out;
      end else if (mi == 3'h0) begin
        ob = {bei, cfg[oog_pkg::MON_BDI_BIT], cfg[oog_pkg::MON_IAE_BIT], 2'b00};
      end else begin
        ob = {bei, cfg[oog_pkg::MON_BDI_BIT],
              fix_stat(cfg[oog_pkg::MON_STAT_LSB +: 3], mi == oog_pkg::MON_PM)};
      end
    end else if (s.pos < oog_pkg::POS_MFAS) begin
      ob = s.fas[(5 - s.pos) * 8 +: 8];
    end else if (s.pos == oog_pkg::POS_MFAS) begin
      ob = s.mfas;
    end else if (s.pos >= oog_pkg::POS_GCC && s.pos < oog_pkg::POS_TCM) begin
      ob = s.gcc[(s.pos - oog_pkg::POS_GCC) * 8 +: 8];
    end else if (s.pos == oog_pkg::POS_FTFL) begin
      fb = ftfl_mem[s.bank][s.mfas];
      // Reserved fault codes are sent as 00 only in frames 0 and 128
      if (s.mfas[6:0] == 7'h00 && fb > oog_pkg::FIF_SD) begin
        fb = oog_pkg::FIF_NONE;
      end
      ob = fb;
    end else if (s.pos == oog_pkg::POS_MUX) begin
      ob = {ts25, m3, m2, 1'b0, slots};
    end else begin
      ob = pay_data;
    end
    // Frame sequencer
    n.tx_valid = s.en;
    n.tx_sof = 1'b0;
    n.tx_pay = 1'b0;
    if (s.en) begin
      n.tx_data = ob;
      n.tx_sof = s.pos == oog_pkg::POS_FAS;
      n.tx_pay = s.pos > oog_pkg::POS_MUX;
      n.pos = s.pos + 6'h01;
      if (s.pos > oog_pkg::POS_MUX) begin
        n.bip_acc = s.bip_acc ^ pay_data;
      end
      if (s.pos == oog_pkg::POS_LAST) begin
        n.bip_prev = n.bip_acc;
        n.bip_out = s.bip_prev;
        n.bip_acc = 8'h00;
        n.mfas = s.mfas + 8'h01;
        if (s.mfas == 8'hff && s.pend) begin
          n.bank = ~s.bank;
          n.fas = s.fas_sh;
          n.mon = s.mon_sh;
          n.gcc = s.gcc_sh;
          n.mux = s.mux_sh;
          n.pend = 1'b0;
        end
      end
    end
    // Bus write; address and data may arrive in either order
    if (awvalid && s.awready) begin
      n.aw_held = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_held = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = oog_pkg::RESP_OKAY;
      if (wa == oog_pkg::ADDR_CTRL) begin
        w = merge({30'h0, s.pend, s.en}, s.wdata, s.wstrb);
        n.en = w[oog_pkg::CTRL_EN_BIT];
        // Commit request set wins over the boundary clear
        if (w[oog_pkg::CTRL_COMMIT_BIT]) begin
          n.pend = 1'b1;
        end
      end else if (wa == oog_pkg::ADDR_FAS_LO) begin
        n.fas_sh[47:16] = merge(s.fas_sh[47:16], s.wdata, s.wstrb);
      end else if (wa == oog_pkg::ADDR_FAS_HI) begin
        w = merge({16'h0, s.fas_sh[15:0]}, s.wdata, s.wstrb);
        n.fas_sh[15:0] = w[15:0];
      end else if (wa == oog_pkg::ADDR_GCC) begin
        w = merge({8'h0, s.gcc_sh}, s.wdata, s.wstrb);
        n.gcc_sh = w[23:0];
      end else if (wa == oog_pkg::ADDR_MUX) begin
        w = merge({8'h0, s.mux_sh}, s.wdata, s.wstrb);
        n.mux_sh = w[23:0];
      end else if (wa >= oog_pkg::ADDR_MON0 && wa <= oog_pkg::ADDR_MON7) begin
        w = merge({21'h0, s.mon_sh[wa[4:2]]}, s.wdata, s.wstrb);
        n.mon_sh[wa[4:2]] = w[10:0];
      end else if (wa == oog_pkg::ADDR_TTI_WR || wa == oog_pkg::ADDR_FTFL_WR) begin
        n.bresp = oog_pkg::RESP_OKAY;
      end else begin
        n.bresp = oog_pkg::RESP_SLVERR;
      end
    end
    n.awready = !n.aw_held;
    n.wready = !n.w_held;
    // Bus read
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = oog_pkg::RESP_OKAY;
      n.rdata = 32'h0;
      if (ra == oog_pkg::ADDR_CTRL) begin
        n.rdata = {30'h0, s.pend, s.en};
      end else if (ra == oog_pkg::ADDR_FAS_LO) begin
        n.rdata = s.fas_sh[47:16];
      end else if (ra == oog_pkg::ADDR_FAS_HI) begin
        n.rdata = {16'h0, s.fas_sh[15:0]};
      end else if (ra == oog_pkg::ADDR_GCC) begin
        n.rdata = {8'h0, s.gcc_sh};
      end else if (ra == oog_pkg::ADDR_MUX) begin
        n.rdata = {8'h0, s.mux_sh};
      end else if (ra == oog_pkg::ADDR_STATUS) begin
        n.rdata = {16'h0, 1'b0, m3, slots, 1'b0, ts25, s.pend, s.bank, s.mfas};
      end else if (ra >= oog_pkg::ADDR_MON0 && ra <= oog_pkg::ADDR_MON7) begin
        n.rdata = {21'h0, s.mon_sh[ra[4:2]]};
      end else if (ra == oog_pkg::ADDR_TTI_WR || ra == oog_pkg::ADDR_FTFL_WR) begin
        n.rdata = 32'h0;
      end else begin
        n.rresp = oog_pkg::RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.fas_sh <= oog_pkg::FAS_RST;
      s.fas <= oog_pkg::FAS_RST;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign tx_data = s.tx_data;
  assign tx_valid = s.tx_valid;
  assign tx_sof = s.tx_sof;
  assign tx_pay = s.tx_pay;
  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  fas_byte_a: assert property (s.en && s.pos == oog_pkg::POS_FAS |=> tx_data == $past(s.fas[47:40]))
    else $error("first alignment byte wrong");
  mfas_step_a: assert property (s.en && s.pos == oog_pkg::POS_LAST |=> s.mfas == 8'($past(s.mfas) + 8'h01))
    else $error("multiframe count did not step");
  mfas_out_a: assert property (s.en && s.pos == oog_pkg::POS_MFAS |=> tx_data == $past(s.mfas))
    else $error("multiframe byte wrong");
  sm_biae_a: assert property (s.en && s.pos == oog_pkg::POS_SM + 6'h02 && s.mon[0][oog_pkg::MON_BIAE_BIT]
      |=> tx_data[7:4] == oog_pkg::BEI_BIAE)
    else $error("alignment error code missing");
  sm_bits_a: assert property (s.en && s.pos == oog_pkg::POS_SM + 6'h02
      |=> tx_data[3] == $past(s.mon[0][oog_pkg::MON_BDI_BIT]) && tx_data[2] == $past(s.mon[0][oog_pkg::MON_IAE_BIT])
      && tx_data[1:0] == 2'b00)
    else $error("section third byte flags wrong");
  bei_range_a: assert property (s.en && s.pos == oog_pkg::POS_SM + 6'h02 && !s.mon[0][oog_pkg::MON_BIAE_BIT]
      |=> tx_data[7:4] <= oog_pkg::BEI_MAX)
    else $error("error count out of range");
  tcm_stat_a: assert property (s.en && s.pos == oog_pkg::POS_TCM + 6'h02
      |=> tx_data[2:0] != oog_pkg::STAT_RES_A && tx_data[2:0] != oog_pkg::STAT_RES_B)
    else $error("reserved tandem status sent");
  pm_byte_a: assert property (s.en && s.pos == oog_pkg::POS_PM + 6'h02
      |=> tx_data[7:4] != oog_pkg::BEI_BIAE && tx_data[2:0] != oog_pkg::STAT_NOSRC)
    else $error("path third byte illegal");
  bip_delay_a: assert property (s.en && s.pos == oog_pkg::POS_SM + 6'h01 |=> tx_data == $past(s.bip_out))
    else $error("parity byte wrong");
  bank_swap_a: assert property ($changed(s.bank) |-> $past(s.mfas) == 8'hff && $past(s.pos) == oog_pkg::POS_LAST)
    else $error("bank swapped off boundary");
  fif_ok_a: assert property (s.en && s.pos == oog_pkg::POS_FTFL && s.mfas[6:0] == 7'h00 |=> tx_data <= oog_pkg::FIF_SD)
    else $error("reserved fault code sent");
endmodule : oog_top

//--- test/oog_rx_model.sv
`timescale 1ns/1ns
// Far-end receiver: rebuilds frames from the line stream and keeps payload parity history
module oog_rx_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_sof,
  input wire logic tx_pay,
  output logic [7:0] frm [64],
  output logic [7:0] par2,
  output logic [3:0] sm_viol,
  output int frame_cnt
);
  logic [7:0] cur [64];
  logic [7:0] acc;
  logic [7:0] p0;
  logic [7:0] p1;
  int idx;

  // Sink reading: 1011 and other codes above eight carry no count
  function automatic logic [3:0] viol(input logic [7:0] b);
    return (b[7:4] > 4'h8) ? 4'h0 : b[7:4];
  endfunction : viol

  always @(posedge clk_sys) begin
    if (rst) begin
      idx = 0;
      frame_cnt <= 0;
      acc = 8'h00;
      p0 = 8'h00;
      p1 = 8'h00;
    end else if (tx_valid) begin
      if (tx_sof) begin
        // A partial first frame after enable is never published
        if (idx == 64) begin
          frm <= cur;
          frame_cnt <= frame_cnt + 1;
          par2 <= p1;
          sm_viol <= viol(cur[9]);
        end
        p1 = p0;
        p0 = acc;
        acc = 8'h00;
        idx = 0;
      end
      if (idx < 64) cur[idx] = tx_data;
      if (tx_pay) acc ^= tx_data;
      idx++;
    end
  end
endmodule : oog_rx_model

//--- test/tb_otn_overhead_generator.sv
`timescale 1ns/1ns
module tb_otn_overhead_generator;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [7:0] pay_data = 8'h00;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [7:0] tx_data;
  logic tx_valid, tx_sof, tx_pay, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, d, mux;
  logic [7:0] frm [64];
  logic [7:0] par2, old0, mf, e;
  logic [3:0] sm_viol;
  logic [7:0] fas [6] = '{8'hf6, 8'hf6, 8'hf6, 8'h28, 8'h28, 8'h28};
  logic [7:0] gcc [3];
  logic [7:0] tti [8][64];
  logic [7:0] ftfl [256];
  logic [10:0] mon [8];
  logic [31:0] mux_tab [3] = '{32'h00a10107, 32'h00700003, 32'h00a10402};
  int frame_cnt, k;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  oog_top dut_u (.clk_sys(clk_sys), .rst(rst), .pay_data(pay_data), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_sof(tx_sof), .tx_pay(tx_pay), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  oog_rx_model rx_u (.clk_sys(clk_sys), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid), .tx_sof(tx_sof),
    .tx_pay(tx_pay), .frm(frm), .par2(par2), .sm_viol(sm_viol), .frame_cnt(frame_cnt));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Three commit rounds of 256 frames each dominate the run
  always @(posedge clk_sys) begin
    pay_data <= 8'($urandom);
    cycles++;
    if (cycles == 90000) begin
      errors++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        rs = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask : axr

  task automatic nextf();
    int w;
    w = frame_cnt;
    while (frame_cnt == w) @(posedge clk_sys);
  endtask : nextf

  function automatic logic [7:0] exp3(input int m, input logic [10:0] v);
    logic [3:0] bei;
    logic [2:0] st;
    bei = (v[3:0] > 4'h8) ? 4'h0 : v[3:0];
    if (m != 7 && v[4]) bei = 4'hb;
    st = v[10:8];
    if (m == 0) return {bei, v[5], v[6], 2'h0};
    if (m == 7) return {bei, v[5], (st >= 3'h5) ? st : 3'h1};
    return {bei, v[5], (st == 3'h3 || st == 3'h4) ? 3'h0 : st};
  endfunction : exp3

  function automatic logic [7:0] expmux(input logic [31:0] x);
    logic [4:0] m1;
    logic [2:0] m2;
    logic m3, ts;
    logic [1:0] sl;
    m1 = x[4:0];
    m2 = (m1 == 5'h0 || m1 > 5'h13 || x[10:8] > 3'h4) ? 3'h0 : x[10:8];
    m3 = x[16] && m2 != 3'h0 && (x[23:20] == oog_pkg::OTU_3 || x[23:20] == oog_pkg::OTU_4);
    ts = m1 inside {5'h07, 5'h08, 5'h0b, 5'h0e, 5'h11};
    sl = (m1 inside {5'h01, 5'h06, 5'h0f, 5'h10}) ? 2'h1 : (m1 == 5'h02) ? 2'h2 : (m1 inside {[5'h03:5'h05]}) ? 2'h3 : 2'h0;
    return {ts, m3, m2, 1'h0, sl};
  endfunction : expmux

  task automatic chkf();
    mf = frm[6];
    for (int i = 0; i < 6; i++) check(frm[i], fas[i]);
    check(frm[7], tti[0][mf[5:0]]);
    check(frm[8], par2);
    check(frm[9], exp3(0, mon[0]));
    check(sm_viol, (mon[0][4] || mon[0][3:0] > 4'h8) ? 4'h0 : mon[0][3:0]);
    for (int i = 0; i < 3; i++) check(frm[10 + i], gcc[i]);
    for (int m = 1; m < 7; m++) begin
      check(frm[10 + 3 * m], tti[m][mf[5:0]]);
      check(frm[11 + 3 * m], par2);
      check(frm[12 + 3 * m], exp3(m, mon[m]));
    end
    e = ftfl[mf];
    if (mf[6:0] == 7'h00 && e > 8'h02) e = 8'h00;
    check(frm[31], e);
    check(frm[32], tti[7][mf[5:0]]);
    check(frm[33], par2);
    check(frm[34], exp3(7, mon[7]));
    check(frm[35], expmux(mux));
  endtask : chkf

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  initial begin
    void'($urandom(73));
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    axr(oog_pkg::ADDR_FAS_LO);
    check(d, 32'hf6f6f628);
    axr(oog_pkg::ADDR_FAS_HI);
    check(d, 32'h00002828);
    axr(8'h40);
    check(rs, oog_pkg::RESP_SLVERR);
    check(d, 32'h00000000);
    axw(8'h44, 32'h00000001);
    check(rs, oog_pkg::RESP_SLVERR);
    check(tx_valid, 1'h0);
    // Stream stopped: these land in the live bank, so frame 0 carries a known fault code
    axw(oog_pkg::ADDR_FTFL_WR, 32'h00000005);
    axw(oog_pkg::ADDR_FTFL_WR, 32'h00008001);
    axw(oog_pkg::ADDR_CTRL, 32'h00000001);
    nextf();
    check(frm[6], 8'h00);
    check(frm[31], oog_pkg::FIF_NONE);
    nextf();
    for (int i = 0; i < 6; i++) check(frm[i], fas[i]);
    check(frm[6], 8'h01);
    $display("test defaults done");
    for (int r = 0; r < 3; r++) begin
      old0 = fas[0];
      for (int i = 0; i < 6; i++) fas[i] = 8'($urandom);
      for (int i = 0; i < 3; i++) gcc[i] = 8'($urandom);
      axw(oog_pkg::ADDR_FAS_LO, {fas[0], fas[1], fas[2], fas[3]});
      axw(oog_pkg::ADDR_FAS_HI, {16'h0000, fas[4], fas[5]});
      axw(oog_pkg::ADDR_GCC, {8'h00, gcc[2], gcc[1], gcc[0]});
      for (int m = 0; m < 8; m++) begin
        mon[m] = 11'($urandom);
        axw(oog_pkg::ADDR_MON0 + 8'(4 * m), {21'h000000, mon[m]});
        for (int b = 0; b < 64; b++) begin
          tti[m][b] = 8'($urandom);
          axw(oog_pkg::ADDR_TTI_WR, {15'h0000, 9'(m * 64 + b), tti[m][b]});
        end
      end
      for (int i = 0; i < 256; i++) begin
        ftfl[i] = (i == 0) ? 8'(r + 1) : 8'($urandom);
        axw(oog_pkg::ADDR_FTFL_WR, {16'h0000, 8'(i), ftfl[i]});
      end
      mux = mux_tab[r];
      axw(oog_pkg::ADDR_MUX, mux);
      nextf();
      nextf();
      check(frm[0], old0);
      axw(oog_pkg::ADDR_CTRL, 32'h00000003);
      axr(oog_pkg::ADDR_STATUS);
      check(d[oog_pkg::ST_PEND_BIT], 1'h1);
      // Always step once: a frame 255 already on hand went out before the commit
      for (k = 0; k < 300; k++) begin
        nextf();
        if (frm[6] === 8'hff) break;
      end
      for (k = 0; k < 3; k++) begin
        nextf();
        check(frm[6], k);
        chkf();
      end
      axr(oog_pkg::ADDR_STATUS);
      check(d[oog_pkg::ST_PEND_BIT], 1'h0);
      $display("test round %0d done", r);
    end
    close_out();
  end
endmodule : tb_otn_overhead_generator
